/* File: core/wqs_id_match.sv */
// Expansion device matcher for the top write-address bits.
// Assumes both inputs are already on the write clock.
`timescale 1ns/1ps
module wqs_id_match (
   // Address and own code
   input wire logic [wqs_pkg::ADDR_W-1:0] addr_in,
   input wire logic [wqs_pkg::ID_W-1:0] device_id_in,
   // Result
   output logic match_out
);
   import wqs_pkg::*;
   assign match_out = (addr_in[ID_MSB:ID_LSB] == device_id_in);
endmodule

/* File: core/wqs_pkg.sv */
// Package for the write-port queue and quadrant select block.
// Assumes a single write clock domain; shared by all design files.
package wqs_pkg;
   localparam int ADDR_W = 8;
   localparam int QUEUE_W = 5;
   localparam int QUAD_W = 2;
   localparam int ID_W = 3;
   localparam int ID_LSB = 5;
   localparam int ID_MSB = 7;
   localparam int QUEUE_MSB = 4;
   localparam int QUAD_MSB = 1;
   localparam logic [QUEUE_W-1:0] QUEUE_RST = 5'h00;
   localparam logic [QUAD_W-1:0] QUAD_RST = 2'h0;
   localparam logic [ID_W-1:0] DEVICE_ID_DEFAULT = 3'h0;

   // Strobes and address from the write-side controller
   typedef struct packed {
      logic [ADDR_W-1:0] write_queue_address_bus;
      logic write_address_strobe;
      logic flag_quadrant_strobe;
   } wqs_cmd_t;

   // Selection state seen by the write datapath
   typedef struct packed {
      logic [QUEUE_W-1:0] pending_queue;
      logic [QUEUE_W-1:0] write_queue;
      logic [QUAD_W-1:0] flag_quadrant;
   } wqs_sel_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_LIVE = 3'b100
   } wqs_state_t;
endpackage

/* File: core/wqs_select.sv */
// Write-port queue and flag quadrant selection.
// Assumes the controller drives address and strobes synchronous to clk_in.
// Assumes the own ID code stays fixed while the block runs.

`timescale 1ns/1ps
module wqs_select (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Own expansion ID
   input wire logic [wqs_pkg::ID_W-1:0] device_id_in,
   // Controller command
   input wire wqs_pkg::wqs_cmd_t cmd_in,
   // Selection state
   output wqs_pkg::wqs_sel_t sel_out,
   output logic [wqs_pkg::QUAD_W-1:0] quadrant_out,
   output logic [wqs_pkg::QUEUE_W-1:0] write_queue_out,
   output logic switch_busy_out
);
   import wqs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Command decode
   logic id_match;
   logic [QUEUE_W-1:0] addr_queue;
   logic [QUAD_W-1:0] addr_quad;
   logic queue_sel;
   logic quad_sel;

   // Switch sequencer
   wqs_state_t state_q;
   wqs_state_t state_d;
   logic commit;
   logic switch_busy;

   // Queue registers
   logic [QUEUE_W-1:0] pending_q;
   logic [QUEUE_W-1:0] pending_d;
   logic [QUEUE_W-1:0] active_q;
   logic [QUEUE_W-1:0] active_d;

   // Quadrant register
   logic [QUAD_W-1:0] quad_q;
   logic [QUAD_W-1:0] quad_d;

   ////////////////////////////////////////////////////////////////////////
   // expansion ID compare
   wqs_id_match u_match (
      .addr_in(cmd_in.write_queue_address_bus),
      .device_id_in(device_id_in),
      .match_out(id_match)
   );

   assign addr_queue = cmd_in.write_queue_address_bus[QUEUE_MSB:0];

   assign addr_quad = cmd_in.write_queue_address_bus[QUAD_MSB:0];

   always_comb begin
      queue_sel = 1'b0;
      quad_sel = 1'b0;
      if (id_match) begin
         if (cmd_in.write_address_strobe) begin
            queue_sel = 1'b1;
         end else if (cmd_in.flag_quadrant_strobe) begin
            quad_sel = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // old queue kept two edges
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (queue_sel) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // A fresh select restarts the two-edge wait
            if (queue_sel) begin
               state_d = ST_WAIT;
            end else begin
               state_d = ST_LIVE;
            end
         end
         ST_LIVE: begin
            if (queue_sel) begin
               state_d = ST_WAIT;
            end else begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            // A broken one-hot code falls back to idle
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_comb begin
      commit = 1'b0;
      switch_busy = 1'b0;
      case (state_q)
         ST_IDLE: begin
            commit = 1'b0;
            switch_busy = 1'b0;
         end
         ST_WAIT: begin
            // A select on this edge defers the switch once more
            commit = !queue_sel;
            switch_busy = 1'b1;
         end
         ST_LIVE: begin
            commit = 1'b0;
            switch_busy = 1'b0;
         end
         default: begin
            // Never commit from a broken code
            commit = 1'b0;
            switch_busy = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // latch requested queue
   always_comb begin
      if (queue_sel) begin
         pending_d = addr_queue;
      end else begin
         pending_d = pending_q;
      end
   end

   // Reset leaves queue zero selected
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pending_q <= QUEUE_RST;
      end else begin
         pending_q <= pending_d;
      end
   end

   always_comb begin
      if (commit) begin
         active_d = pending_q;
      end else begin
         active_d = active_q;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         active_q <= QUEUE_RST;
      end else begin
         active_q <= active_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // quadrant from low two bits
   always_comb begin
      if (quad_sel) begin
         quad_d = addr_quad;
      end else begin
         quad_d = quad_q;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         quad_q <= QUAD_RST;
      end else begin
         quad_q <= quad_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data outputs come straight from the registers
   always_comb begin
      sel_out = '0;
      sel_out.pending_queue = pending_q;
      sel_out.write_queue = active_q;
      sel_out.flag_quadrant = quad_q;
   end

   assign quadrant_out = quad_q;
   assign write_queue_out = active_q;

   // Busy while the old queue is still the write target
   assign switch_busy_out = switch_busy;
endmodule

/* File: sim/tb_top.sv */
// Bench for the select block.
// Assumes the controller model makes every command.
`timescale 1ns/1ps
module tb_top;
   import wqs_pkg::*;
   logic clk_in = 0, reset_in = 1, done_n = 1;
   logic [2:0] id = 3'h5;
   wqs_cmd_t cmd;
   wqs_sel_t sel;
   logic [1:0] quad;
   logic [4:0] wq;
   logic busy;
   int errors = 0, compares = 0;
   always #5 clk_in = ~clk_in;
   wqs_ctrl wqs_ctrl_inst (.clk_in(clk_in),
      .serial_program_done_n_in(done_n), .cmd_out(cmd));
   wqs_select wqs_select_inst (.clk_in(clk_in), .reset_in(reset_in),
      .device_id_in(id), .cmd_in(cmd), .sel_out(sel), .quadrant_out(quad),
      .write_queue_out(wq), .switch_busy_out(busy));
   task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s exp %h got %h", n, exp, got);
      end
   endtask
   task automatic step(logic [7:0] a, logic qs, logic fs);
      wqs_ctrl_inst.send(a, qs, fs);
      #1;
   endtask
   task automatic t_queue;
      step({id, 5'h1f}, 1, 0);
      step(8'h00, 0, 0);
      chk("pending", sel.pending_queue, 8'h1f);
      chk("busy", busy, 8'h01);
      chk("old", wq, 8'h00);
      step(8'h00, 0, 0);
      chk("new", wq, 8'h1f);
      step({id, 5'h03}, 1, 0);
      step({id, 5'h15}, 1, 0);
      step(8'h00, 0, 0);
      chk("restart", wq, 8'h1f);
      step(8'h00, 0, 0);
      chk("second", wq, 8'h15);
      $display("queue test done");
   endtask
   task automatic t_quad;
      for (int n = 0; n < 4; n++) begin
         step({id, 3'h7, n[1:0]}, 0, 1);
         step(8'h00, 0, 0);
         chk("quad", quad, n[7:0]);
         chk("queue", wq, 8'h15);
      end
      step({id ^ 3'h1, 5'h02}, 1, 0);
      step({id ^ 3'h1, 5'h01}, 0, 1);
      step(8'h00, 0, 0);
      step(8'h00, 0, 0);
      chk("foreign", {quad, wq}, 8'h75);
      chk("foreign pending", sel.pending_queue, 8'h15);
      $display("quadrant test done");
   endtask
   task automatic end_of_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      #1 chk("reset", {busy, quad, wq}, 8'h00);
      chk("reset pending", sel.pending_queue, 8'h00);
      @(posedge clk_in);
      reset_in <= 0;
      repeat (2) @(posedge clk_in);
      done_n <= 0;
      t_queue;
      t_quad;
      end_of_test;
   end
   // Tests need about 25 cycles
   initial begin
      #5000 errors++;
      end_of_test;
   end
endmodule
bind wqs_select wqs_sva wqs_sva_inst (.clk_in(clk_in), .reset_in(reset_in),
   .device_id_in(device_id_in), .cmd_in(cmd_in), .sel_out(sel_out),
   .quadrant_out(quadrant_out), .write_queue_out(write_queue_out),
   .switch_busy_out(switch_busy_out));

/* File: sim/wqs_ctrl.sv */
// Write-side controller model.
// Assumes the bench calls send once per clock.
`timescale 1ns/1ps
module wqs_ctrl import wqs_pkg::*; (
   input wire logic clk_in,
   input wire logic serial_program_done_n_in,
   output wqs_cmd_t cmd_out
);
   initial cmd_out = '0;
   task automatic send(input logic [7:0] a, input logic qs, input logic fs);
      do @(posedge clk_in); while (serial_program_done_n_in);
      cmd_out <= '{(qs | fs) ? a : ~cmd_out.write_queue_address_bus, qs,
         fs && !qs};
   endtask
endmodule

/* File: sim/wqs_sva.sv */
// Port checker for the select block.
// Assumes one write clock and async high reset.
`timescale 1ns/1ps
module wqs_sva import wqs_pkg::*; (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [ID_W-1:0] device_id_in,
   input wire wqs_cmd_t cmd_in,
   input wire wqs_sel_t sel_out,
   input wire logic [QUAD_W-1:0] quadrant_out,
   input wire logic [QUEUE_W-1:0] write_queue_out,
   input wire logic switch_busy_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire logic [7:0] a = cmd_in.write_queue_address_bus;
   wire logic m = a[7:5] == device_id_in;
   wire logic q = cmd_in.write_address_strobe && m;
   wire logic f = cmd_in.flag_quadrant_strobe && !q && m;
   sequence s_sel; q ##1 !q; endsequence
   a_queue_latch: assert property (
      q |=> sel_out.pending_queue == $past(a[4:0])) else $error("pending");
   a_queue_live: assert property (
      s_sel |=> write_queue_out == $past(a[4:0], 2)) else $error("live");
   a_busy_flag: assert property (
      q |=> switch_busy_out && $stable(write_queue_out)) else $error("old");
   a_busy_only: assert property (
      !$past(q) |-> !switch_busy_out) else $error("busy");
   a_quad_pick: assert property (
      f |=> quadrant_out == $past(a[1:0])) else $error("quadrant");
   a_quad_keep: assert property (
      f |=> $stable(sel_out.pending_queue)) else $error("quad queue");
   a_idle_hold: assert property (
      !q && !f |=> $stable(sel_out.pending_queue) && $stable(quadrant_out))
      else $error("hold");
   a_out_mirror: assert property (
      quadrant_out == sel_out.flag_quadrant) else $error("mirror");
   a_queue_mirror: assert property (
      write_queue_out == sel_out.write_queue) else $error("queue mirror");
   a_queue_steady: assert property (
      !$past(switch_busy_out) |-> $stable(sel_out.write_queue))
      else $error("queue moved");
endmodule
